// File: verilog/virtual_clutch.v
// Virtual-axis clutch: address mode 2 and one-shot mode, evaluated once per operation cycle
`timescale 1ns/1ns
`include "clutch_regs.vh"

module virtual_clutch #(
  parameter [31:0] OP_DIV = `CLT_OP_DIV
) (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire [7:0]  i_addr,
  input  wire [31:0] i_wr_data,
  input  wire        i_wr_en,
  input  wire        i_rd_en,
  output wire [31:0] o_rd_data,
  input  wire [31:0] i_axis_pos,
  input  wire [31:0] i_pos_delta,
  input  wire        i_major_err,
  output wire        o_clutch_on,
  output wire        o_mode_err,
  output wire        o_op_tick
);

  // ----------------------------------------------------------------
  // One-shot phases
  // ----------------------------------------------------------------
  localparam [1:0] PH_IDLE   = 2'h0;
  localparam [1:0] PH_BEFORE = 2'h1;
  localparam [1:0] PH_AFTER  = 2'h2;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // True when the axis moved onto or across the target since last cycle
  function reached;
    input signed [31:0] prev;
    input signed [31:0] cur;
    input signed [31:0] tgt;
    begin
      reached = ((prev < tgt) && (cur >= tgt)) || ((prev > tgt) && (cur <= tgt));
    end
  endfunction

  // Travel is complete once it has gone as far as the target, in its direction
  function travel_done;
    input signed [31:0] acc;
    input signed [31:0] tgt;
    begin
      if (tgt[31])
        travel_done = (acc <= tgt);
      else
        travel_done = (acc >= tgt);
    end
  endfunction

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  reg [31:0] div_cnt_ff;
  reg        op_tick_ff;
  reg        cmd_ff;
  reg        err_off_ff;
  reg [2:0]  mode_ff;
  reg        mode_err_ff;
  reg [31:0] on_addr_ff;
  reg [31:0] off_addr_ff;
  reg [31:0] rd_data_ff;
  reg        cmd_prev_ff;
  reg [31:0] pos_prev_ff;
  reg        int_on_ff;
  reg        clutch_ff;
  reg        hold_ff;
  reg [1:0]  phase_ff;
  reg [31:0] acc_ff;
  reg [31:0] tgt_before_ff;
  reg [31:0] tgt_after_ff;

  reg        nxt_int_on;
  reg        nxt_hold;
  reg [1:0]  nxt_phase;
  reg [31:0] nxt_acc;
  reg [31:0] nxt_tgt_before;
  reg [31:0] nxt_tgt_after;
  reg        nxt_mode_err;
  reg [31:0] nxt_rd_data;

  wire [31:0] acc_sum = acc_ff + i_pos_delta;
  wire        wr_mode = i_wr_en && (i_addr == `CLT_MODE_OFS);
  wire        mode_bad = (i_wr_data > `CLT_MODE_MAX);
  wire        cmd_rise = cmd_ff && !cmd_prev_ff;

  // ----------------------------------------------------------------
  // Operation cycle divider
  // ----------------------------------------------------------------
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      div_cnt_ff <= 32'h0000_0000;
      op_tick_ff <= 1'b0;
    end
    else if (div_cnt_ff >= OP_DIV - 32'h0000_0001)
    begin
      div_cnt_ff <= 32'h0000_0000;
      op_tick_ff <= 1'b1;
    end
    else
    begin
      div_cnt_ff <= div_cnt_ff + 32'h0000_0001;
      op_tick_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_mode_err = mode_err_ff;
    if (i_wr_en && (i_addr == `CLT_STATUS_OFS) && i_wr_data[`CLT_ST_MODE_ERR_BIT])
      nxt_mode_err = 1'b0;
    // A new bad write wins over a clear in the same cycle
    if (wr_mode && mode_bad)
      nxt_mode_err = 1'b1;
  end

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      cmd_ff      <= 1'b0;
      err_off_ff  <= 1'b0;
      mode_ff     <= `CLT_MODE_RST;
      mode_err_ff <= 1'b0;
      on_addr_ff  <= `CLT_ADDR_RST;
      off_addr_ff <= `CLT_ADDR_RST;
    end
    else
    begin
      mode_err_ff <= nxt_mode_err;
      if (i_wr_en && (i_addr == `CLT_CTRL_OFS))
      begin
        cmd_ff     <= i_wr_data[`CLT_CTRL_CMD_BIT];
        err_off_ff <= i_wr_data[`CLT_CTRL_ERR_OFF_BIT];
      end
      if (wr_mode && !mode_bad)
        mode_ff <= i_wr_data[2:0];
      if (i_wr_en && (i_addr == `CLT_ON_ADDR_OFS))
        on_addr_ff <= i_wr_data;
      if (i_wr_en && (i_addr == `CLT_OFF_ADDR_OFS))
        off_addr_ff <= i_wr_data;
    end
  end

  // ----------------------------------------------------------------
  // Register reads
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_rd_data = 32'h0000_0000;
    case (i_addr)
      `CLT_CTRL_OFS:
      begin
        nxt_rd_data[`CLT_CTRL_CMD_BIT]     = cmd_ff;
        nxt_rd_data[`CLT_CTRL_ERR_OFF_BIT] = err_off_ff;
      end
      `CLT_MODE_OFS:     nxt_rd_data[2:0] = mode_ff;
      `CLT_ON_ADDR_OFS:  nxt_rd_data = on_addr_ff;
      `CLT_OFF_ADDR_OFS: nxt_rd_data = off_addr_ff;
      `CLT_STATUS_OFS:
      begin
        nxt_rd_data[`CLT_ST_CLUTCH_BIT]   = clutch_ff;
        nxt_rd_data[`CLT_ST_MODE_ERR_BIT] = mode_err_ff;
        nxt_rd_data[3:2]                  = phase_ff;
        nxt_rd_data[`CLT_ST_HOLD_BIT]     = hold_ff;
      end
      `CLT_TRAVEL_OFS:   nxt_rd_data = acc_ff;
      default:           nxt_rd_data = 32'h0000_0000;
    endcase
  end

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
      rd_data_ff <= 32'h0000_0000;
    else if (i_rd_en)
      rd_data_ff <= nxt_rd_data;
    else
      rd_data_ff <= 32'h0000_0000;
  end

  // ----------------------------------------------------------------
  // Clutch evaluation, one pass per operation cycle
  // ----------------------------------------------------------------
  always @*
  begin
    nxt_int_on     = int_on_ff;
    nxt_hold       = hold_ff;
    nxt_phase      = phase_ff;
    nxt_acc        = acc_ff;
    nxt_tgt_before = tgt_before_ff;
    nxt_tgt_after  = tgt_after_ff;
    if (op_tick_ff)
    begin
      case (mode_ff)
        `CLT_MODE_ADDR2:
        begin
          nxt_phase = PH_IDLE;
          if (!cmd_ff || hold_ff)
            nxt_int_on = 1'b0;
          else if (!int_on_ff)
          begin
            // Both addresses can fall inside one cycle of travel; the one met
            // second decides, so a round trip leaves the visible flag as it was
            if (reached(pos_prev_ff, i_axis_pos, on_addr_ff))
              nxt_int_on = !reached(on_addr_ff, i_axis_pos, off_addr_ff);
          end
          else if (reached(pos_prev_ff, i_axis_pos, off_addr_ff))
            nxt_int_on = reached(off_addr_ff, i_axis_pos, on_addr_ff);
        end
        `CLT_MODE_OS_ON, `CLT_MODE_OS_NO:
        begin
          case (phase_ff)
            PH_IDLE:
            begin
              nxt_int_on = 1'b0;
              nxt_acc    = 32'h0000_0000;
              if ((mode_ff == `CLT_MODE_OS_ON) && cmd_rise && !hold_ff)
              begin
                // Settings are captured here; later edits wait for the next edge
                nxt_tgt_before = off_addr_ff;
                nxt_tgt_after  = on_addr_ff;
                if (off_addr_ff == 32'h0000_0000)
                begin
                  nxt_int_on = 1'b1;
                  nxt_phase  = PH_AFTER;
                end
                else
                  nxt_phase = PH_BEFORE;
              end
            end
            PH_BEFORE:
            begin
              nxt_acc = acc_sum;
              if (travel_done(acc_sum, tgt_before_ff))
              begin
                nxt_int_on = 1'b1;
                nxt_acc    = 32'h0000_0000;
                nxt_phase  = PH_AFTER;
              end
            end
            PH_AFTER:
            begin
              nxt_acc = acc_sum;
              if (travel_done(acc_sum, tgt_after_ff))
              begin
                nxt_int_on = 1'b0;
                nxt_phase  = PH_IDLE;
              end
            end
            default:
            begin
              nxt_int_on = 1'b0;
              nxt_phase  = PH_IDLE;
            end
          endcase
        end
        default:
        begin
          // Modes without logic here keep the clutch released
          nxt_int_on = 1'b0;
          nxt_phase  = PH_IDLE;
        end
      endcase
      if (hold_ff && !cmd_ff)
        nxt_hold = 1'b0;
      if (err_off_ff && i_major_err)
      begin
        nxt_hold   = 1'b1;
        nxt_int_on = 1'b0;
        nxt_phase  = PH_IDLE;
      end
    end
  end

  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      int_on_ff     <= 1'b0;
      clutch_ff     <= 1'b0;
      hold_ff       <= 1'b0;
      phase_ff      <= PH_IDLE;
      acc_ff        <= 32'h0000_0000;
      tgt_before_ff <= 32'h0000_0000;
      tgt_after_ff  <= 32'h0000_0000;
      cmd_prev_ff   <= 1'b0;
      pos_prev_ff   <= 32'h0000_0000;
    end
    else
    begin
      int_on_ff     <= nxt_int_on;
      hold_ff       <= nxt_hold;
      phase_ff      <= nxt_phase;
      acc_ff        <= nxt_acc;
      tgt_before_ff <= nxt_tgt_before;
      tgt_after_ff  <= nxt_tgt_after;
      if (op_tick_ff)
      begin
        clutch_ff   <= nxt_int_on;
        cmd_prev_ff <= cmd_ff;
        pos_prev_ff <= i_axis_pos;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign o_rd_data   = rd_data_ff;
  assign o_clutch_on = clutch_ff;
  assign o_mode_err  = mode_err_ff;
  assign o_op_tick   = op_tick_ff;

endmodule // virtual_clutch

// File: verilog/clutch_regs.vh
// Register map, field positions, mode codes and timing counts of the clutch block
`ifndef CLUTCH_REGS_VH
`define CLUTCH_REGS_VH

// ----------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------
`define CLT_CTRL_OFS     8'h00
`define CLT_MODE_OFS     8'h04
`define CLT_ON_ADDR_OFS  8'h08
`define CLT_OFF_ADDR_OFS 8'h0c
`define CLT_STATUS_OFS   8'h10
`define CLT_TRAVEL_OFS   8'h14

// ----------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------
`define CLT_CTRL_CMD_BIT     0
`define CLT_CTRL_ERR_OFF_BIT 1
`define CLT_ST_CLUTCH_BIT    0
`define CLT_ST_MODE_ERR_BIT  1
`define CLT_ST_HOLD_BIT      4

// ----------------------------------------------------------------
// Mode codes and reset values
// ----------------------------------------------------------------
`define CLT_MODE_MAX   32'h0000_0004
`define CLT_MODE_ADDR2 3'h2
`define CLT_MODE_OS_ON 3'h3
`define CLT_MODE_OS_NO 3'h4
`define CLT_MODE_RST   3'h0
`define CLT_ADDR_RST   32'h0000_0000

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define CLT_CLK_NS      10
`define CLT_OP_CYCLE_NS 1000
`define CLT_OP_DIV      (`CLT_OP_CYCLE_NS / `CLT_CLK_NS)

`endif

// File: test/virtual_clutch_sva.sv
// Concurrent checks on the clutch block ports
`timescale 1ns/1ns
module virtual_clutch_sva #(
  parameter [31:0] OP_DIV = 32'h4
) (
  input wire        i_clk,
  input wire        i_sys_rst,
  input wire [7:0]  i_addr,
  input wire [31:0] i_wr_data,
  input wire        i_wr_en,
  input wire        i_rd_en,
  input wire [31:0] o_rd_data,
  input wire [31:0] i_axis_pos,
  input wire [31:0] i_pos_delta,
  input wire        i_major_err,
  input wire        o_clutch_on,
  input wire        o_mode_err,
  input wire        o_op_tick
);
  reg  [2:0]  mode_ff;
  reg  [1:0]  ctrl_ff;
  reg  [31:0] on_ff, off_ff, prev_ff, cnt_ff;
  reg         hold_ff, seen_ff;
  wire        armed;
  function automatic logic hit(input logic signed [31:0] p, c, a);
    hit = (p < a && a <= c) || (p > a && a >= c);
  endfunction
  // Shadows latch settings the same way the block does, so ticks see old values
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      mode_ff <= 3'h0;
      ctrl_ff <= 2'h0;
      on_ff   <= 32'h0;
      off_ff  <= 32'h0;
      prev_ff <= 32'h0;
      cnt_ff  <= 32'h0;
      hold_ff <= 1'b0;
      seen_ff <= 1'b0;
    end
    else
    begin
      if (i_wr_en && i_addr == 8'h00) ctrl_ff <= i_wr_data[1:0];
      if (i_wr_en && i_addr == 8'h04 && i_wr_data <= 32'h4) mode_ff <= i_wr_data[2:0];
      if (i_wr_en && i_addr == 8'h08) on_ff <= i_wr_data;
      if (i_wr_en && i_addr == 8'h0c) off_ff <= i_wr_data;
      cnt_ff <= o_op_tick ? 32'h0 : cnt_ff + 32'h1;
      if (o_op_tick)
      begin
        prev_ff <= i_axis_pos;
        seen_ff <= 1'b1;
        if (i_major_err && ctrl_ff[1]) hold_ff <= 1'b1;
        else if (!ctrl_ff[0]) hold_ff <= 1'b0;
      end
    end
  end
  assign armed = o_op_tick && mode_ff == 3'h2 && ctrl_ff[0] && !hold_ff
                 && !(i_major_err && ctrl_ff[1]);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  sequence s_on_hit;
    armed && !o_clutch_on && hit(prev_ff, i_axis_pos, on_ff) && !hit(prev_ff, i_axis_pos, off_ff);
  endsequence
  // The off address met with no on address after it within one cycle releases the clutch
  sequence s_off_hit;
    armed && o_clutch_on && hit(prev_ff, i_axis_pos, off_ff)
    && !hit(off_ff, i_axis_pos, on_ff);
  endsequence
  // Travel that meets the on address and then the off address within one cycle
  sequence s_trip;
    armed && !o_clutch_on && hit(prev_ff, i_axis_pos, on_ff)
    && hit(on_ff, i_axis_pos, off_ff);
  endsequence
  property p_on; s_on_hit |=> o_clutch_on; endproperty
  property p_off; s_off_hit |=> !o_clutch_on; endproperty
  property p_trip; s_trip |=> !o_clutch_on; endproperty
  property p_tick; o_op_tick && seen_ff |-> cnt_ff == OP_DIV - 32'h1; endproperty
  property p_steady; !$stable(o_clutch_on) |-> $past(o_op_tick); endproperty
  property p_rd_idle; !i_rd_en |=> o_rd_data == 32'h0; endproperty
  property p_mode_err; i_wr_en && i_addr == 8'h04 && i_wr_data > 32'h4 |=> o_mode_err; endproperty
  property p_mode_rd; i_rd_en && i_addr == 8'h04 |=> o_rd_data == {29'h0, mode_ff}; endproperty
  property p_cmd_off; o_op_tick && mode_ff == 3'h2 && !ctrl_ff[0] |=> !o_clutch_on; endproperty
  property p_err_off; o_op_tick && i_major_err && ctrl_ff[1] |=> !o_clutch_on; endproperty
  a_on: assert property (p_on) else $error("no engage at on address");
  a_off: assert property (p_off) else $error("no release at off address");
  a_trip: assert property (p_trip) else $error("round trip changed clutch flag");
  a_tick: assert property (p_tick) else $error("operation cycle length wrong");
  a_steady: assert property (p_steady) else $error("clutch moved off a tick");
  a_rd_idle: assert property (p_rd_idle) else $error("read data not idle");
  a_mode_err: assert property (p_mode_err) else $error("bad mode not flagged");
  a_mode_rd: assert property (p_mode_rd) else $error("mode not kept");
  a_cmd_off: assert property (p_cmd_off) else $error("clutch on with command low");
  a_err_off: assert property (p_err_off) else $error("clutch on after major error");
endmodule // virtual_clutch_sva

// File: test/drive_model.sv
// Behavioural drive module feeding the virtual axis once per operation cycle
`timescale 1ns/1ns
module drive_model (
  input  wire        i_clk,
  input  wire        i_sys_rst,
  input  wire        i_tick,
  input  wire [31:0] i_step,
  output reg  [31:0] o_pos,
  output reg  [31:0] o_delta
);
  // Position and delta move together so delta is always travel since the last tick
  always @(posedge i_clk)
  begin
    if (i_sys_rst)
    begin
      o_pos   <= 32'h0;
      o_delta <= 32'h0;
    end
    else if (i_tick)
    begin
      o_pos   <= o_pos + i_step;
      o_delta <= i_step;
    end
  end
endmodule // drive_model

// File: test/test_virtual_clutch.sv
// Self-checking bench of the clutch block
`timescale 1ns/1ns
`include "clutch_regs.vh"
`define CHK(a,e) begin cmp_count++; if ((a) !== (e)) begin error_cnt++; \
  $display("wrong value at %0t: got %h expected %h", $time, a, e); end end
module test_virtual_clutch;
  localparam [7:0] CT = `CLT_CTRL_OFS, MD = `CLT_MODE_OFS, ON = `CLT_ON_ADDR_OFS;
  localparam [7:0] OF = `CLT_OFF_ADDR_OFS, ST = `CLT_STATUS_OFS;
  reg          clk, sys_rst, wen, ren, merr, ren_d;
  reg  [7:0]   addr;
  reg  [31:0]  wdat, step, rnd;
  wire [31:0]  rdat, pos, dlt;
  wire         clutch, mode_err, tick;
  integer      error_cnt, cmp_count, seed;
  logic [63:0] notes[$];
  logic [63:0] nt;
  virtual_clutch #(.OP_DIV(32'h4)) i_dut (.i_clk(clk), .i_sys_rst(sys_rst), .i_addr(addr),
    .i_wr_data(wdat), .i_wr_en(wen), .i_rd_en(ren), .o_rd_data(rdat), .i_axis_pos(pos),
    .i_pos_delta(dlt), .i_major_err(merr), .o_clutch_on(clutch), .o_mode_err(mode_err),
    .o_op_tick(tick));
  drive_model i_drv (.i_clk(clk), .i_sys_rst(sys_rst), .i_tick(tick), .i_step(step),
    .o_pos(pos), .o_delta(dlt));
  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end
  task close_out;
    $display("comparisons %0d errors %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  // Strobes stay up from one call to the next, so back-to-back transfers need no gap;
  // tk lowers them before any idle time
  task wr(input [7:0] a, input [31:0] d);
    addr <= a;
    wdat <= d;
    wen  <= 1'b1;
    ren  <= 1'b0;
    @(posedge clk);
  endtask
  task rd(input [7:0] a, input [31:0] m, input [31:0] e);
    addr <= a;
    ren  <= 1'b1;
    wen  <= 1'b0;
    notes.push_back({m, e});
    @(posedge clk);
  endtask
  task st(input e);
    rd(ST, 32'h1, {31'h0, e});
  endtask
  // Returns in the time step of a tick edge, so the clutch has just been evaluated
  task tk(input integer n);
    integer k, g;
    wen <= 1'b0;
    ren <= 1'b0;
    for (k = 0; k < n; k++)
    begin
      g = 0;
      @(posedge clk);
      while (tick !== 1'b1 && g < 20)
      begin
        @(posedge clk);
        g++;
      end
      if (g == 20)
      begin
        error_cnt++;
        close_out();
      end
    end
  endtask
  // The delta reaches the block one tick after the move is launched
  task move(input [31:0] d);
    step <= d;
    tk(1);
    step <= 32'h0;
    tk(1);
  endtask
  always @(posedge clk)
  begin
    ren_d <= ren;
    if (ren_d === 1'b1)
    begin
      nt = notes.pop_front();
      `CHK(rdat & nt[63:32], nt[31:0])
    end
  end
  initial
  begin
    seed = 32'hc676;
    error_cnt = 0;
    cmp_count = 0;
    {sys_rst, wen, ren, merr, ren_d, addr, wdat, step} = {5'h10, 8'h0, 64'h0};
    repeat (5) @(posedge clk);
    sys_rst <= 1'b0;
    @(posedge clk);
    rd(MD, 32'h7, 32'h0);
    rd(8'h20, 32'hffff_ffff, 32'h0);
    rnd = $random(seed);
    wr(ON, rnd);
    rd(ON, 32'hffff_ffff, rnd);
    rnd = $random(seed);
    wr(OF, rnd);
    rd(OF, 32'hffff_ffff, rnd);
    wr(MD, 32'h2);
    wr(MD, 32'h7);
    rd(MD, 32'h7, 32'h2);
    `CHK(mode_err, 1'b1)
    wr(ST, 32'h2);
    rd(ST, 32'h2, 32'h0);
    wr(ON, 32'd10);
    wr(OF, 32'd30);
    wr(CT, 32'h1);
    move(32'd10);
    st(1'b1);
    move(32'd10);
    st(1'b1);
    move(32'd15);
    st(1'b0);
    move(-32'd25);
    st(1'b1);
    wr(CT, 32'h0);
    tk(1);
    st(1'b0);
    move(32'd25);
    move(-32'd25);
    st(1'b0);
    wr(CT, 32'h1);
    move(32'd5);
    st(1'b0);
    move(-32'd5);
    st(1'b1);
    move(32'd25);
    st(1'b0);
    wr(ON, 32'd40);
    wr(OF, 32'd50);
    move(32'd20);
    st(1'b0);
    move(-32'd10);
    move(-32'd10);
    st(1'b1);
    wr(CT, 32'h3);
    merr <= 1'b1;
    tk(1);
    merr <= 1'b0;
    st(1'b0);
    move(32'd10);
    st(1'b0);
    wr(CT, 32'h2);
    tk(1);
    wr(CT, 32'h3);
    move(-32'd10);
    st(1'b1);
    wr(CT, 32'h0);
    wr(MD, 32'h3);
    wr(OF, 32'd8);
    wr(ON, -32'd12);
    tk(2);
    wr(CT, 32'h1);
    move(32'd5);
    st(1'b0);
    move(32'd5);
    st(1'b1);
    wr(CT, 32'h0);
    move(-32'd5);
    st(1'b1);
    move(-32'd10);
    st(1'b0);
    wr(OF, 32'h0);
    wr(ON, 32'd3);
    wr(CT, 32'h1);
    tk(1);
    st(1'b1);
    move(32'd3);
    st(1'b0);
    wr(CT, 32'h0);
    wr(OF, 32'd4);
    tk(1);
    wr(CT, 32'h1);
    tk(1);
    wr(MD, 32'h4);
    move(32'd4);
    st(1'b1);
    move(32'd3);
    st(1'b0);
    wr(CT, 32'h0);
    wr(OF, 32'h0);
    tk(1);
    wr(CT, 32'h1);
    tk(1);
    st(1'b0);
    wr(MD, 32'h3);
    wr(CT, 32'h0);
    tk(1);
    wr(CT, 32'h1);
    tk(1);
    st(1'b1);
    tk(1);
    close_out();
  end
endmodule // test_virtual_clutch
bind virtual_clutch virtual_clutch_sva #(.OP_DIV(OP_DIV)) i_sva (.i_clk(i_clk),
  .i_sys_rst(i_sys_rst), .i_addr(i_addr), .i_wr_data(i_wr_data), .i_wr_en(i_wr_en),
  .i_rd_en(i_rd_en), .o_rd_data(o_rd_data), .i_axis_pos(i_axis_pos),
  .i_pos_delta(i_pos_delta), .i_major_err(i_major_err), .o_clutch_on(o_clutch_on),
  .o_mode_err(o_mode_err), .o_op_tick(o_op_tick));
